//--- nvm_dev.sv
// Purpose: program flash and data EEPROM access logic
// Assumes: core end keeps one request outstanding and waits while stall is high
// Notes: flash and EEPROM contents are arrays with no reset
`timescale 1ns/100ps
`default_nettype none
module nvm_dev #(
	parameter int PM_BYTES = nvm_pkg::PM_BYTES,
	parameter int PM_AW = nvm_pkg::PM_AW,
	parameter int EE_BYTES = nvm_pkg::EE_BYTES
) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	// Link to the core end
	nvm_link_if.dev bus
);
	typedef enum logic [1:0] {UL_IDLE, UL_GOT1, UL_ARMED} nvm_unlock_type;

	logic [7:0] pm [PM_BYTES];
	logic [7:0] ee_mem [EE_BYTES];
	logic [7:0] hold [nvm_pkg::WR_BLOCK];

	logic [7:0] ee_address_reg;
	logic [7:0] ee_data_reg;
	logic [7:0] table_latch_reg;
	logic memory_select_bit, config_select_bit, write_done_flag;
	logic write_allow_bit, write_trig, read_trig;
	nvm_unlock_type unlock;
	logic ee_busy, fl_busy;
	logic [nvm_pkg::CNT_W-1:0] ee_cnt, fl_cnt;
	nvm_pkg::nvm_cmd_type fl_kind;
	logic [PM_AW-1:0] fl_addr;
	logic take, ee_start, ee_end, fl_end, bulk_refuse;
	logic [7:0] ctl_view;

	function automatic logic reg_wr(input logic [2:0] idx);
		reg_wr = take && bus.cmd == nvm_pkg::CMD_REG_WR && bus.addr[2:0] == idx;
	endfunction

	// ==========================================
	// Request decode
	assign take = bus.req && !fl_busy;
	assign bulk_refuse = take && bus.cmd == nvm_pkg::CMD_BULK && bus.user_code;
	assign ee_end = ee_busy && ee_cnt == '0;
	assign fl_end = fl_busy && fl_cnt == '0;
	// Needs armed unlock and write-allow already set before this write
	assign ee_start = reg_wr(nvm_pkg::IDX_EE_CTRL) && bus.wdata[nvm_pkg::B_WR] && !ee_busy
		&& unlock == UL_ARMED && write_allow_bit;
	assign ctl_view = {memory_select_bit, config_select_bit, 1'b0, write_done_flag,
		1'b0, write_allow_bit, write_trig, read_trig};

	// ==========================================
	// Unlock tracker
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			unlock <= UL_IDLE;
		end else if (take && bus.cmd == nvm_pkg::CMD_REG_WR) begin
			if (bus.addr[2:0] == nvm_pkg::IDX_EE_UNLOCK && bus.wdata == nvm_pkg::UNLOCK_1) begin
				unlock <= UL_GOT1;
			end else if (bus.addr[2:0] == nvm_pkg::IDX_EE_UNLOCK && unlock == UL_GOT1
				&& bus.wdata == nvm_pkg::UNLOCK_2) begin
				unlock <= UL_ARMED;
			end else begin
				unlock <= UL_IDLE;
			end
		end
	end

	// ==========================================
	// EEPROM control register
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			memory_select_bit <= 1'b0;
			config_select_bit <= 1'b0;
			write_allow_bit <= 1'b0;
			read_trig <= 1'b0;
		end else if (reg_wr(nvm_pkg::IDX_EE_CTRL) && !ee_busy) begin
			memory_select_bit <= bus.wdata[nvm_pkg::B_MSEL];
			config_select_bit <= bus.wdata[nvm_pkg::B_CSEL];
			write_allow_bit <= bus.wdata[nvm_pkg::B_WRITE_ALLOW_BIT];
			read_trig <= bus.wdata[nvm_pkg::B_RD];
		end else begin
			read_trig <= 1'b0;
		end
	end

	// Write trigger and done flag: hardware set wins over host clear
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			write_trig <= 1'b0;
			write_done_flag <= 1'b0;
		end else begin
			if (ee_start) begin
				write_trig <= 1'b1;
			end else if (ee_end) begin
				write_trig <= 1'b0;
			end
			if (ee_end) begin
				write_done_flag <= 1'b1;
			end else if (reg_wr(nvm_pkg::IDX_EE_CTRL) && !ee_busy) begin
				write_done_flag <= bus.wdata[nvm_pkg::B_DONE];
			end
		end
	end

	// ==========================================
	// EEPROM address, data and self-timed write
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			ee_address_reg <= 8'h00;
		end else if (reg_wr(nvm_pkg::IDX_EE_ADDR) && !ee_busy) begin
			ee_address_reg <= bus.wdata;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			ee_data_reg <= 8'h00;
		end else if (read_trig && !memory_select_bit && !config_select_bit) begin
			ee_data_reg <= ee_mem[ee_address_reg];
		end else if (reg_wr(nvm_pkg::IDX_EE_DATA) && !ee_busy) begin
			ee_data_reg <= bus.wdata;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			ee_busy <= 1'b0;
			ee_cnt <= '0;
		end else if (ee_start) begin
			ee_busy <= 1'b1;
			ee_cnt <= nvm_pkg::CNT_W'(nvm_pkg::EE_WRITE_CYC - 1);
		end else if (ee_end) begin
			ee_busy <= 1'b0;
		end else if (ee_busy) begin
			ee_cnt <= ee_cnt - 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (ee_end) begin
			ee_mem[ee_address_reg] <= ee_data_reg;
		end
	end

	// ==========================================
	// Table latch and holding registers
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			table_latch_reg <= 8'h00;
		end else if (take && bus.cmd == nvm_pkg::CMD_TBL_RD) begin
			table_latch_reg <= pm[bus.addr];
		end else if ((take && bus.cmd == nvm_pkg::CMD_TBL_WR)
			|| reg_wr(nvm_pkg::IDX_TBL_LATCH)) begin
			table_latch_reg <= bus.wdata;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (take && bus.cmd == nvm_pkg::CMD_TBL_WR) begin
			hold[bus.addr[2:0]] <= bus.wdata;
		end
	end

	// ==========================================
	// Flash write and erase sequencer
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			fl_busy <= 1'b0;
			fl_cnt <= '0;
			fl_kind <= nvm_pkg::CMD_FL_WR;
			fl_addr <= '0;
		end else if (take && !bulk_refuse && (bus.cmd == nvm_pkg::CMD_FL_WR
			|| bus.cmd == nvm_pkg::CMD_FL_ER || bus.cmd == nvm_pkg::CMD_BULK)) begin
			fl_busy <= 1'b1;
			fl_cnt <= nvm_pkg::CNT_W'(nvm_pkg::FL_PROG_CYC - 1);
			fl_kind <= bus.cmd;
			fl_addr <= bus.addr;
		end else if (fl_end) begin
			fl_busy <= 1'b0;
		end else if (fl_busy) begin
			fl_cnt <= fl_cnt - 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (fl_end) begin
			for (int i = 0; i < PM_BYTES; i++) begin
				if (fl_kind == nvm_pkg::CMD_BULK) begin
					pm[i] <= nvm_pkg::ERASED;
				end else if (fl_kind == nvm_pkg::CMD_FL_ER && (i / nvm_pkg::ER_BLOCK)
					== int'(fl_addr) / nvm_pkg::ER_BLOCK) begin
					pm[i] <= nvm_pkg::ERASED;
				end else if (fl_kind == nvm_pkg::CMD_FL_WR && (i / nvm_pkg::WR_BLOCK)
					== int'(fl_addr) / nvm_pkg::WR_BLOCK) begin
					pm[i] <= hold[i % nvm_pkg::WR_BLOCK];
				end
			end
		end
	end

	// ==========================================
	// Answers
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			bus.ack <= 1'b0;
			bus.refused <= 1'b0;
			bus.rdata <= 8'h00;
		end else begin
			bus.ack <= fl_end || bulk_refuse || (take && bus.cmd != nvm_pkg::CMD_FL_WR
				&& bus.cmd != nvm_pkg::CMD_FL_ER && bus.cmd != nvm_pkg::CMD_BULK);
			bus.refused <= bulk_refuse;
			if (take && bus.cmd == nvm_pkg::CMD_TBL_RD) begin
				bus.rdata <= pm[bus.addr];
			end else if (take && bus.cmd == nvm_pkg::CMD_REG_RD) begin
				if (bus.addr[2:0] == nvm_pkg::IDX_EE_ADDR) begin
					bus.rdata <= ee_address_reg;
				end else if (bus.addr[2:0] == nvm_pkg::IDX_EE_DATA) begin
					bus.rdata <= ee_data_reg;
				end else if (bus.addr[2:0] == nvm_pkg::IDX_EE_CTRL) begin
					bus.rdata <= ctl_view;
				end else if (bus.addr[2:0] == nvm_pkg::IDX_TBL_LATCH) begin
					bus.rdata <= table_latch_reg;
				end else begin
					bus.rdata <= 8'h00;
				end
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			bus.stall <= 1'b0;
			bus.ee_flag <= 1'b0;
		end else begin
			bus.stall <= (take && !bulk_refuse && (bus.cmd == nvm_pkg::CMD_FL_WR
				|| bus.cmd == nvm_pkg::CMD_FL_ER || bus.cmd == nvm_pkg::CMD_BULK))
				|| (fl_busy && !fl_end);
			bus.ee_flag <= ee_end || (write_done_flag
				&& !(reg_wr(nvm_pkg::IDX_EE_CTRL) && !ee_busy && !bus.wdata[nvm_pkg::B_DONE]));
		end
	end
endmodule
`default_nettype wire

//--- nvm_pkg.sv
// Purpose: shared constants for the nonvolatile access block and its core end
// Assumes: one clock at 125 MHz
// Notes: device register indices are reached through the link command channel
`default_nettype none
package nvm_pkg;
	// ==========================================
	// Clock and self-timed periods
	localparam int CLK_NS = 8;
	localparam int FL_PROG_TIME_NS = 2000;
	localparam int EE_WRITE_TIME_NS = 4000;
	localparam int FL_PROG_CYC = (FL_PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int EE_WRITE_CYC = (EE_WRITE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 12;

	// ==========================================
	// Memory geometry
	localparam int PM_BYTES = 1024;
	localparam int PM_AW = 10;
	localparam int EE_BYTES = 256;
	localparam int EE_AW = 8;
	localparam int WR_BLOCK = 8;
	localparam int ER_BLOCK = 64;
	localparam logic [7:0] ERASED = 8'hff;

	// ==========================================
	// Link commands
	typedef enum logic [2:0] {
		CMD_REG_WR = 3'h0,
		CMD_REG_RD = 3'h1,
		CMD_TBL_RD = 3'h2,
		CMD_TBL_WR = 3'h3,
		CMD_FL_WR = 3'h4,
		CMD_FL_ER = 3'h5,
		CMD_BULK = 3'h6
	} nvm_cmd_type;

	// ==========================================
	// Device register indices
	localparam logic [2:0] IDX_EE_ADDR = 3'h0;
	localparam logic [2:0] IDX_EE_DATA = 3'h1;
	localparam logic [2:0] IDX_EE_CTRL = 3'h2;
	localparam logic [2:0] IDX_EE_UNLOCK = 3'h3;
	localparam logic [2:0] IDX_TBL_LATCH = 3'h4;

	// Control register bits and unlock codes
	localparam int B_MSEL = 7;
	localparam int B_CSEL = 6;
	localparam int B_DONE = 4;
	localparam int B_WRITE_ALLOW_BIT = 2;
	localparam int B_WR = 1;
	localparam int B_RD = 0;
	localparam logic [7:0] UNLOCK_1 = 8'h55;
	localparam logic [7:0] UNLOCK_2 = 8'haa;

	// ==========================================
	// Core APB registers (byte addresses) and interrupt event bits
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_ADDR = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_INT_STAT = 8'h0c;
	localparam logic [7:0] A_INT_CLR = 8'h10;
	localparam logic [7:0] A_INT_EN = 8'h14;
	localparam int EV_W = 4;
	localparam int EV_DONE = 0;
	localparam int EV_REFUSED = 1;
	localparam int EV_EE_DONE = 2;
	localparam int EV_DROPPED = 3;
endpackage
`default_nettype wire

//--- nvm_link_if.sv
// Purpose: link between the core end and the nonvolatile access device
// Assumes: one clock shared by both ends
// Notes: one request at a time, answered by a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
interface nvm_link_if #(parameter int ADDR_W = nvm_pkg::PM_AW);
	logic req;
	nvm_pkg::nvm_cmd_type cmd;
	logic [ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic user_code;
	logic ack;
	logic refused;
	logic [7:0] rdata;
	logic stall;
	logic ee_flag;

	modport dev (
		input req, cmd, addr, wdata, user_code,
		output ack, refused, rdata, stall, ee_flag
	);
	modport core (
		output req, cmd, addr, wdata, user_code,
		input ack, refused, rdata, stall, ee_flag
	);
endinterface
`default_nettype wire

//--- nvm_core.sv
// Purpose: core end: takes orders over APB and drives the device link
// Assumes: APB master holds each request until pready
// Notes: pready answers one cycle after setup
`timescale 1ns/100ps
`default_nettype none
module nvm_core #(
	parameter int ADDR_W = nvm_pkg::PM_AW
) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	// Interrupt
	output logic O_IRQ,
	// Link to the device
	nvm_link_if.core bus
);
	logic wr_acc, pending, issued, last_refused, ee_flag_d;
	logic [7:0] last_rdata;
	logic [nvm_pkg::EV_W-1:0] int_stat, int_en, ev;
	logic [ADDR_W-1:0] op_addr;

	assign wr_acc = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
	assign ev = {wr_acc && I_PADDR == nvm_pkg::A_CMD && pending,
		bus.ee_flag && !ee_flag_d, bus.ack && bus.refused, bus.ack};

	// ==========================================
	// APB answer
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
		end else begin
			O_PREADY <= I_PSEL && !I_PENABLE;
			if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
				if (I_PADDR == nvm_pkg::A_ADDR) begin
					O_PRDATA <= 32'(op_addr);
				end else if (I_PADDR == nvm_pkg::A_STATUS) begin
					O_PRDATA <= {16'h0000, last_rdata, 4'h0, ee_flag_d, last_refused,
						bus.stall, pending};
				end else if (I_PADDR == nvm_pkg::A_INT_STAT) begin
					O_PRDATA <= 32'(int_stat);
				end else if (I_PADDR == nvm_pkg::A_INT_EN) begin
					O_PRDATA <= 32'(int_en);
				end else begin
					O_PRDATA <= 32'h0000_0000;
				end
			end
		end
	end

	// ==========================================
	// Command issue: one request outstanding, a command written while one is pending is dropped
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			op_addr <= '0;
		end else if (wr_acc && I_PADDR == nvm_pkg::A_ADDR) begin
			op_addr <= I_PWDATA[ADDR_W-1:0];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			pending <= 1'b0;
			issued <= 1'b0;
			bus.req <= 1'b0;
			bus.cmd <= nvm_pkg::CMD_REG_RD;
			bus.addr <= '0;
			bus.wdata <= 8'h00;
			bus.user_code <= 1'b0;
		end else begin
			bus.req <= 1'b0;
			if (wr_acc && I_PADDR == nvm_pkg::A_CMD && !pending) begin
				pending <= 1'b1;
				bus.cmd <= nvm_pkg::nvm_cmd_type'(I_PWDATA[10:8]);
				bus.wdata <= I_PWDATA[7:0];
				bus.user_code <= I_PWDATA[11];
				bus.addr <= op_addr;
			end else if (pending && !issued && !bus.stall && !bus.req) begin
				bus.req <= 1'b1;
				issued <= 1'b1;
			end else if (issued && bus.ack) begin
				pending <= 1'b0;
				issued <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			last_rdata <= 8'h00;
			last_refused <= 1'b0;
			ee_flag_d <= 1'b0;
		end else begin
			ee_flag_d <= bus.ee_flag;
			if (bus.ack) begin
				last_rdata <= bus.rdata;
				last_refused <= bus.refused;
			end
		end
	end

	// ==========================================
	// Interrupt status, clear and enable
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			int_stat <= '0;
			int_en <= '0;
			O_IRQ <= 1'b0;
		end else begin
			if (wr_acc && I_PADDR == nvm_pkg::A_INT_CLR) begin
				int_stat <= (int_stat & ~I_PWDATA[nvm_pkg::EV_W-1:0]) | ev;
			end else begin
				int_stat <= int_stat | ev;
			end
			if (wr_acc && I_PADDR == nvm_pkg::A_INT_EN) begin
				int_en <= I_PWDATA[nvm_pkg::EV_W-1:0];
			end
			O_IRQ <= |(int_stat & int_en);
		end
	end
endmodule
`default_nettype wire

//--- nvm_link_assertions.sv
// Purpose: protocol checks on the link between the core end and the device
// Assumes: sees the link signals as plain inputs, one clock domain
// Notes: cycle figures follow the link timing of the device end
`timescale 1ns/100ps
`default_nettype none
module nvm_link_assertions #(parameter int ADDR_W = nvm_pkg::PM_AW) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	// Link signals
	input wire logic req,
	input wire nvm_pkg::nvm_cmd_type cmd,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic user_code,
	input wire logic ack,
	input wire logic refused,
	input wire logic [7:0] rdata,
	input wire logic stall,
	input wire logic ee_flag
);
	// ==========================================
	// Helpers
	logic take;
	logic fl;
	logic [9:0] stall_cnt;
	assign take = req && !stall;
	assign fl = (cmd == nvm_pkg::CMD_FL_WR) || (cmd == nvm_pkg::CMD_FL_ER);
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N || !stall) begin
			stall_cnt <= 10'h000;
		end else begin
			stall_cnt <= stall_cnt + 10'h001;
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	// ==========================================
	// Assertions
	a_bulk_user_refused: assert property (
		take && cmd == nvm_pkg::CMD_BULK && user_code |=> ack && refused)
		else $error("user bulk erase not refused");
	a_refused_cause: assert property (
		refused |-> ack && $past(req && cmd == nvm_pkg::CMD_BULK && user_code))
		else $error("refusal without user bulk erase");
	a_flash_stalls: assert property (take && fl |=> stall [*8])
		else $error("flash operation does not stall");
	a_flash_timed_end: assert property (take && fl |=> ##250 ack)
		else $error("flash operation not ended by timer");
	a_stall_bound: assert property (stall_cnt <= 10'd250)
		else $error("stall lasts too long");
	a_short_ack: assert property (
		take && cmd inside {nvm_pkg::CMD_REG_WR, nvm_pkg::CMD_REG_RD, nvm_pkg::CMD_TBL_RD,
		nvm_pkg::CMD_TBL_WR} |=> ack && !refused && !stall)
		else $error("register or table op not answered next cycle");
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_rdata_holds: assert property ($changed(rdata) |-> ack)
		else $error("read data changed without an answer");
	a_flag_sticky: assert property (
		ee_flag && !(take && cmd == nvm_pkg::CMD_REG_WR && addr[2:0] == nvm_pkg::IDX_EE_CTRL)
		|=> ee_flag)
		else $error("write done flag cleared by hardware");
	a_ack_has_cause: assert property ($rose(ack) |-> $past(req) || $past(stall))
		else $error("answer without request");
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for core end and device joined by the link
// Assumes: APB master waits for pready at each rising edge, link ops are polled
// Notes: flash and EEPROM contents start unknown, so each location is written before the bench reads it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic prdy;
	logic irq;
	logic saw_stall = 1'b0;
	int err_count = 0;
	int cmp_count = 0;

	// ==========================================
	// Design and checker
	nvm_link_if link();
	nvm_core i_nvm_core(.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(prdy), .O_IRQ(irq), .bus(link.core));
	nvm_dev i_nvm_dev(.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .bus(link.dev));
	nvm_link_assertions i_chk(.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .req(link.req),
		.cmd(link.cmd), .addr(link.addr), .wdata(link.wdata), .user_code(link.user_code),
		.ack(link.ack), .refused(link.refused), .rdata(link.rdata), .stall(link.stall),
		.ee_flag(link.ee_flag));
	always #4 ref_clk = ~ref_clk;

	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		pen <= 1'b1;
		// Sample pready and read data at the rising edge that ends the access
		do begin
			@(posedge ref_clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 50) err_count++;
	endtask
	// Launch a link command and poll until it is no longer pending
	task automatic op(input logic [2:0] c, input logic [9:0] a, input logic [7:0] d,
		input logic u);
		int n;
		n = 0;
		apb(1'b1, nvm_pkg::A_ADDR, {22'h0, a});
		apb(1'b1, nvm_pkg::A_CMD, {20'h0, u, c, d});
		do begin
			apb(1'b0, nvm_pkg::A_STATUS, 32'h0);
			if (q[1] === 1'b1) saw_stall = 1'b1;
			n++;
		end while (q[0] !== 1'b0 && n < 400);
		if (n >= 400) err_count++;
	endtask
	task automatic ew(input logic [2:0] i, input logic [7:0] d);
		op(3'h0, {7'h0, i}, d, 1'b0);
	endtask
	task automatic rchk(input logic [2:0] i, input logic [7:0] e);
		op(3'h1, {7'h0, i}, 8'h00, 1'b0);
		chk({24'h0, q[15:8]}, {24'h0, e});
	endtask

	// ==========================================
	// Tests
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b0, nvm_pkg::A_STATUS, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
		op(3'h5, 10'h000, 8'h00, 1'b0);
		chk({31'h0, saw_stall}, 32'h1);
		op(3'h3, 10'h003, 8'h5a, 1'b0);
		rchk(3'h4, 8'h5a);
		op(3'h2, 10'h003, 8'h00, 1'b0);
		chk({24'h0, q[15:8]}, 32'hff);
		op(3'h4, 10'h000, 8'h00, 1'b0);
		op(3'h2, 10'h003, 8'h00, 1'b0);
		chk({24'h0, q[15:8]}, 32'h5a);
		op(3'h5, 10'h03f, 8'h00, 1'b0);
		apb(1'b0, nvm_pkg::A_ADDR, 32'h0);
		chk(q, 32'h3f);
		op(3'h2, 10'h003, 8'h00, 1'b0);
		chk({24'h0, q[15:8]}, 32'hff);
		$display("test flash done");
		apb(1'b1, nvm_pkg::A_INT_CLR, 32'hf);
		op(3'h6, 10'h000, 8'h00, 1'b1);
		chk({31'h0, q[2]}, 32'h1);
		apb(1'b0, nvm_pkg::A_INT_STAT, 32'h0);
		chk({31'h0, q[1]}, 32'h1);
		apb(1'b1, nvm_pkg::A_INT_CLR, 32'hf);
		apb(1'b1, nvm_pkg::A_ADDR, 32'h40);
		apb(1'b1, nvm_pkg::A_CMD, 32'h500);
		op(3'h2, 10'h003, 8'h00, 1'b0);
		apb(1'b0, nvm_pkg::A_INT_STAT, 32'h0);
		chk({28'h0, q[3:0]}, 32'h9);
		$display("test bulk done");
		ew(3'h0, 8'h21);
		ew(3'h1, 8'hc3);
		ew(3'h2, 8'h04);
		ew(3'h3, 8'h55);
		ew(3'h3, 8'haa);
		ew(3'h2, 8'h06);
		rchk(3'h2, 8'h06);
		ew(3'h1, 8'h11);
		ew(3'h0, 8'h00);
		rchk(3'h1, 8'hc3);
		for (int n = 0; n < 400 && q[2] !== 1'b1; n++) begin
			apb(1'b0, nvm_pkg::A_INT_STAT, 32'h0);
		end
		chk({31'h0, irq}, 32'h0);
		rchk(3'h2, 8'h14);
		chk({31'h0, q[3]}, 32'h1);
		apb(1'b1, nvm_pkg::A_INT_EN, 32'h4);
		apb(1'b0, nvm_pkg::A_INT_EN, 32'h0);
		chk(q, 32'h4);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, nvm_pkg::A_INT_CLR, 32'h4);
		apb(1'b0, nvm_pkg::A_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test eeprom write done");
		ew(3'h1, 8'h00);
		ew(3'h2, 8'h05);
		rchk(3'h2, 8'h04);
		chk({31'h0, q[3]}, 32'h0);
		rchk(3'h1, 8'hc3);
		$display("test eeprom read done");
		ew(3'h2, 8'h00);
		ew(3'h3, 8'h55);
		ew(3'h3, 8'haa);
		ew(3'h2, 8'h02);
		rchk(3'h2, 8'h00);
		ew(3'h3, 8'h55);
		ew(3'h3, 8'haa);
		ew(3'h2, 8'h06);
		rchk(3'h2, 8'h04);
		ew(3'h3, 8'h55);
		ew(3'h3, 8'h00);
		ew(3'h3, 8'haa);
		ew(3'h2, 8'h06);
		rchk(3'h2, 8'h04);
		$display("test refused writes done");
		stop_test;
	end
	initial begin
		#400000;
		err_count++;
		stop_test;
	end
endmodule
`default_nettype wire
